// File: rtl/asq_pkg.sv
// constants and types for the converter sequencer timing and configuration
package asq_pkg;
    // register byte addresses
    localparam logic [7:0] IRQ_CONFIG_ADDR   = 8'h12;
    localparam logic [7:0] SLEEP_CONFIG_ADDR = 8'h13;
    localparam logic [7:0] ACQ_CONFIG_ADDR   = 8'h14;
    localparam logic [7:0] PWR_CONFIG_ADDR   = 8'h15;
    // field positions
    localparam int IRQ_PULSE_BIT   = 0;
    localparam int IRQ_POL_BIT     = 1;
    localparam int IRQ_SRC_LSB     = 2;
    localparam int SLEEP_CODE_LSB  = 0;
    localparam int SLEEP_MUL_BIT   = 4;
    localparam int SLEEP_DIV_BIT   = 5;
    localparam int HALT_CTRL_BIT   = 6;
    localparam int AMP_EN_BIT      = 5;
    localparam int AMP_POL_BIT     = 6;
    // writable bit masks; other bits read as zero
    localparam logic [7:0] IRQ_CONFIG_MASK   = 8'h1f;
    localparam logic [7:0] SLEEP_CONFIG_MASK = 8'h77;
    localparam logic [7:0] ACQ_CONFIG_MASK   = 8'h1f;
    localparam logic [7:0] PWR_CONFIG_MASK   = 8'h7f;
    localparam logic [7:0] CONFIG_RESET      = 8'h00;
    // interrupt source codes
    localparam logic [2:0] SRC_ALARM_ALARM = 3'h0;
    localparam logic [2:0] SRC_BUSY_ALARM  = 3'h1;
    localparam logic [2:0] SRC_DR1_DR1     = 3'h2;
    localparam logic [2:0] SRC_BUSY_DR1    = 3'h3;
    localparam logic [2:0] SRC_DR4_DR4     = 3'h6;
    localparam logic [2:0] SRC_BUSY_DR4    = 3'h7;
    // timing
    localparam int CLK_FREQ_MHZ  = 200;
    localparam int STEP_TIME_US  = 2;
    localparam int ACQ_BASE_US   = 6;
    localparam int CONV_TIME_US  = 4;
    localparam int SLEEP_BASE_US = 2500;
    localparam int STEP_CYCLES      = STEP_TIME_US * CLK_FREQ_MHZ;
    localparam int ACQ_BASE_CYCLES  = ACQ_BASE_US * CLK_FREQ_MHZ;
    localparam int CONV_CYCLES      = CONV_TIME_US * CLK_FREQ_MHZ;
    localparam int SLEEP_BASE_CYCLES = SLEEP_BASE_US * CLK_FREQ_MHZ;
    localparam int MUL_SHIFT = 3;
    localparam int DIV_SHIFT = 2;
    localparam int NUM_CHANNELS = 4;

    typedef enum logic [2:0] {
        ST_IDLE, ST_PWRUP, ST_ACQ, ST_CONV, ST_SLEEP, ST_HALT
    } asq_state_type;
endpackage : asq_pkg

// File: rtl/asq_sequencer.sv
// measurement sequencer timing, interrupt pin and amplifier power pin
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer
    import asq_pkg::*;
#(
    parameter int SLEEP_BASE = SLEEP_BASE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_we,
    input  wire logic       reg_re,
    output logic      [7:0] reg_rdata,
    input  wire logic       run_en,
    input  wire logic       alarm,
    input  wire logic       status_clear,
    output logic            irq_pin,
    output logic            amp_power_control_pin,
    output logic            busy,
    output logic      [1:0] channel,
    output logic            conv_start
);
    typedef struct packed {
        asq_state_type st;
        logic [31:0]   cnt;
        logic [1:0]    chan;
        logic [4:0]    irq_cfg;
        logic [7:0]    sleep_cfg;
        logic [4:0]    acq_cfg;
        logic [6:0]    pwr_cfg;
        logic          ctrl_flag;
        logic          busy;
        logic          irq_pin;
        logic          amp_pin;
        logic          conv_start;
        logic [7:0]    rdata;
    } asq_regs_type;

    asq_regs_type q, d;

    function automatic logic [31:0] sleep_cycles(input logic [7:0] cfg);
        logic [31:0] c;
        c = 32'(SLEEP_BASE) << cfg[SLEEP_CODE_LSB +: 3];
        if (cfg[SLEEP_MUL_BIT]) c = c << MUL_SHIFT;
        if (cfg[SLEEP_DIV_BIT]) c = c << DIV_SHIFT;
        return c;
    endfunction : sleep_cycles

    logic [31:0] acq_len;
    logic [31:0] pwr_len;
    logic [2:0]  src;
    logic        dr_one;
    logic        dr_all;
    logic        ctrl_evt;
    logic        pin_active;

    assign src     = q.irq_cfg[IRQ_SRC_LSB +: 3];
    assign acq_len = 32'(q.acq_cfg) * 32'(STEP_CYCLES)
                     + 32'(ACQ_BASE_CYCLES);
    assign pwr_len = 32'(q.pwr_cfg[4:0]) * 32'(STEP_CYCLES);

    always_comb begin
        d          = q;
        dr_one     = 1'b0;
        dr_all     = 1'b0;
        ctrl_evt   = 1'b0;
        pin_active = 1'b0;
        d.conv_start = 1'b0;
        // register port
        if (reg_we) begin
            unique case (reg_addr)
                IRQ_CONFIG_ADDR:   d.irq_cfg = reg_wdata[4:0];
                SLEEP_CONFIG_ADDR: d.sleep_cfg = reg_wdata & SLEEP_CONFIG_MASK;
                ACQ_CONFIG_ADDR:   d.acq_cfg = reg_wdata[4:0];
                PWR_CONFIG_ADDR:   d.pwr_cfg = reg_wdata[6:0];
                default: ;
            endcase
        end
        if (reg_re) begin
            unique case (reg_addr)
                IRQ_CONFIG_ADDR:   d.rdata = {3'h0, q.irq_cfg};
                SLEEP_CONFIG_ADDR: d.rdata = q.sleep_cfg;
                ACQ_CONFIG_ADDR:   d.rdata = {3'h0, q.acq_cfg};
                PWR_CONFIG_ADDR:   d.rdata = {1'b0, q.pwr_cfg};
                default:           d.rdata = 8'h00;
            endcase
        end
        // sequencer
        unique case (q.st)
            ST_IDLE: if (run_en) d.st = ST_PWRUP;
            ST_HALT: begin
                if (!run_en) d.st = ST_IDLE;
                else if (!q.ctrl_flag) d.st = ST_PWRUP;
            end
            ST_PWRUP: begin
                if (q.cnt == 32'h0000_0000) begin
                    d.st  = ST_ACQ;
                    d.cnt = acq_len - 32'h0000_0001;
                end else d.cnt = q.cnt - 32'h0000_0001;
            end
            ST_ACQ: begin
                if (q.cnt == 32'h0000_0000) begin
                    d.st         = ST_CONV;
                    d.conv_start = 1'b1;
                    d.cnt        = 32'(CONV_CYCLES) - 32'h0000_0001;
                end else d.cnt = q.cnt - 32'h0000_0001;
            end
            ST_CONV: begin
                if (q.cnt == 32'h0000_0000) begin
                    dr_one = 1'b1;
                    d.chan = q.chan + 2'h1;
                    if (q.chan == 2'(NUM_CHANNELS - 1)) begin
                        dr_all = 1'b1;
                        d.st   = ST_SLEEP;
                        d.cnt  = sleep_cycles(q.sleep_cfg)
                                 - 32'h0000_0001;
                    end else d.st = ST_PWRUP;
                end else d.cnt = q.cnt - 32'h0000_0001;
            end
            ST_SLEEP: begin
                if (q.cnt == 32'h0000_0000)
                    d.st = run_en ? ST_PWRUP : ST_IDLE;
                else d.cnt = q.cnt - 32'h0000_0001;
            end
        endcase
        // control event chosen by the source code
        unique case (src[2:1])
            2'b00:   ctrl_evt = alarm;
            2'b01:   ctrl_evt = dr_one;
            default: ctrl_evt = dr_all;
        endcase
        // set wins over the host's clear
        if (status_clear) d.ctrl_flag = 1'b0;
        if (ctrl_evt) d.ctrl_flag = 1'b1;
        // a fresh channel start: power-up skipped at code zero, or halt
        if (d.st == ST_PWRUP && q.st != ST_PWRUP) begin
            d.cnt = pwr_len - 32'h0000_0001;
            if (pwr_len == 32'h0000_0000) begin
                d.st  = ST_ACQ;
                d.cnt = acq_len - 32'h0000_0001;
            end
            if (q.sleep_cfg[HALT_CTRL_BIT] && d.ctrl_flag)
                d.st = ST_HALT;
        end
        d.busy = d.st inside {ST_PWRUP, ST_ACQ, ST_CONV};
        // pin: busy codes have bit 0 set, others show the event in pulse mode or the control flag in level mode
        if (src[0]) begin
            pin_active = q.irq_cfg[IRQ_PULSE_BIT] ? (d.busy && !q.busy)
                                                  : d.busy;
        end else begin
            pin_active = q.irq_cfg[IRQ_PULSE_BIT] ? ctrl_evt
                                                  : d.ctrl_flag;
        end
        d.irq_pin = q.irq_cfg[IRQ_POL_BIT] ? pin_active : !pin_active;
        // amplifier stays on through power-up, acquire and convert
        d.amp_pin = q.pwr_cfg[AMP_POL_BIT]
                    ? (q.pwr_cfg[AMP_EN_BIT] && d.busy)
                    : !(q.pwr_cfg[AMP_EN_BIT] && d.busy);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q           <= '0;
            q.st        <= ST_IDLE;
            q.irq_pin   <= 1'b1;
            q.amp_pin   <= 1'b1;
            q.sleep_cfg <= CONFIG_RESET;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata             = q.rdata;
    assign irq_pin               = q.irq_pin;
    assign amp_power_control_pin = q.amp_pin;
    assign busy                  = q.busy;
    assign channel               = q.chan;
    assign conv_start            = q.conv_start;

    busy_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        (src[0] && !q.irq_cfg[IRQ_PULSE_BIT] && $stable(q.irq_cfg))
        |-> (irq_pin == (q.irq_cfg[IRQ_POL_BIT] ? busy : !busy)))
        else $error("busy level not on interrupt pin");
    dr_all_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == ST_CONV && q.cnt == 0 && q.chan == 2'h3 && src[2])
        |=> q.ctrl_flag)
        else $error("four-conversion event did not set control flag");
    pol_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!q.irq_cfg[IRQ_POL_BIT] && !src[0] && !q.ctrl_flag
         && !q.irq_cfg[IRQ_PULSE_BIT] && !status_clear && !alarm
         && !(q.st == ST_CONV)) |=> irq_pin)
        else $error("idle active-low pin not high");
    pulse_width_a: assert property (@(posedge clk) disable iff (!reset_n)
        (q.irq_cfg[IRQ_PULSE_BIT] && src[0] && $stable(q.irq_cfg)
         && irq_pin == q.irq_cfg[IRQ_POL_BIT])
        |=> irq_pin != q.irq_cfg[IRQ_POL_BIT])
        else $error("pulse mode held pin longer than one cycle");
    halt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == ST_HALT && run_en && q.ctrl_flag) |=> !busy)
        else $error("conversions resumed while halted");
    sleep_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == ST_CONV && q.cnt == 0 && q.chan == 2'h3
         && q.sleep_cfg[6:4] == 3'b010 && q.sleep_cfg[2:0] == 3'h0)
        |=> q.cnt == 32'(SLEEP_BASE) * 4 - 1)
        else $error("divided sleep length wrong");
    sleep_mul_a: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == ST_CONV && q.cnt == 0 && q.chan == 2'h3
         && q.sleep_cfg[6:4] == 3'b001 && q.sleep_cfg[2:0] == 3'h1)
        |=> q.cnt == 32'(SLEEP_BASE) * 16 - 1)
        else $error("multiplied sleep length wrong");
    acq_min_a: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st != ST_ACQ && d.st == ST_ACQ && q.acq_cfg == 5'h0)
        |=> (q.st == ST_ACQ)[*8] ##0 q.cnt == 32'(ACQ_BASE_CYCLES) - 8)
        else $error("shortest acquisition not 6 us");
    amp_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!q.pwr_cfg[AMP_EN_BIT] && $stable(q.pwr_cfg))
        |-> amp_power_control_pin == !q.pwr_cfg[AMP_POL_BIT])
        else $error("disabled amplifier pin not inactive");
    no_pwrup_a: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st != ST_PWRUP && q.pwr_cfg[4:0] == 5'h0) |=> q.st != ST_PWRUP)
        else $error("power-up entered with zero code");
    alarm_evt_a: assert property (@(posedge clk) disable iff (!reset_n)
        (src[2:1] == 2'b00 && alarm) |=> q.ctrl_flag)
        else $error("alarm did not raise control event");
endmodule : asq_sequencer
`default_nettype wire

// File: tb/asq_host_model.sv
// host side model driving the byte register port of the sequencer
`timescale 1ns/1ps
`default_nettype none
module asq_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_we,
    output var  logic       reg_re
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
    end
    // callers never pass reserved source codes or set always-zero bits
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge clk);
        reg_we = 1'b0;
    endtask : wr
    // read data stands from the edge after the strobe until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_re = 1'b1;
        @(negedge clk);
        reg_re = 1'b0;
        d = reg_rdata;
    endtask : rd
endmodule : asq_host_model
`default_nettype wire

// File: tb/adc_sequencer_timing_config_tb.sv
// self-checking bench for the sequencer timing and configuration block
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_timing_config_tb;
    import asq_pkg::*;
    localparam int SB = 20;
    logic clk = 1'b0, reset_n = 1'b0, run_en = 1'b0;
    logic alarm = 1'b0, status_clear = 1'b0, reg_we, reg_re;
    logic irq_pin, amp_power_control_pin, busy, conv_start;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, d;
    logic [1:0] channel;
    logic [31:0] seed = 32'h0000_f567;
    int err_count = 0, checks_done = 0, n, e, p, a, c;
    logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
    always #2.5 clk = ~clk;
    asq_host_model host (.clk(clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re));
    asq_sequencer #(.SLEEP_BASE(SB)) DUT (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .run_en(run_en),
        .alarm(alarm), .status_clear(status_clear), .irq_pin(irq_pin),
        .amp_power_control_pin(amp_power_control_pin), .busy(busy),
        .channel(channel), .conv_start(conv_start));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", nm, ex, got);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // bounded wait for a level on busy or a conversion start
    task automatic wait_for(input bit on_start, input logic lvl,
                            output int cnt);
        cnt = 0;
        while ((on_start ? conv_start : busy) !== lvl && cnt < 20000) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 20000) begin
            err_count++;
            $display("mismatch wait expected %0h seen timeout", lvl);
        end
    endtask : wait_for
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (2) @(negedge clk);
    endtask : pulse
    initial begin
        // worst case run is about 83k cycles
        #450_000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        chk("irq_rst", 1, irq_pin);
        chk("amp_rst", 1, amp_power_control_pin);
        for (int i = 0; i < 5; i++) begin
            d = 8'h12 + 8'(i);
            host.rd(d, rv);
            chk("reg_rst", 0, rv);
            n = rnd();
            rv = (i == 0) ? 8'(n) & 8'h0f : (i == 1) ? 8'(n) & 8'h77 :
                 (i == 2) ? 8'(n) & 8'h1f : (i == 3) ? 8'(n) & 8'h7f : 8'(n);
            host.wr(d, rv);
            host.rd(d, d);
            chk("reg_rw", (i == 4) ? 8'h00 : rv, d);
        end
        p = rnd() % 4;
        a = rnd() % 4;
        c = rnd() % 4;
        n = rnd() % 4;
        host.wr(PWR_CONFIG_ADDR, 8'h60 | 8'(p));
        host.wr(ACQ_CONFIG_ADDR, 8'(a));
        host.wr(SLEEP_CONFIG_ADDR, 8'(c) | 8'(n << 4));
        host.wr(IRQ_CONFIG_ADDR, 8'h06);
        run_en = 1'b1;
        wait_for(1, 1'b1, e);
        chk("start", (p + a) * STEP_CYCLES + ACQ_BASE_CYCLES + 1, e);
        chk("amp_on", 1, amp_power_control_pin);
        chk("irq_busy", 1, irq_pin);
        repeat (4) wait_for(0, 1'b0, e);
        @(negedge clk);
        chk("amp_off", 0, amp_power_control_pin);
        wait_for(0, 1'b1, e);
        p = ((SB << c) << (n[0] ? 3 : 0) << (n[1] ? 2 : 0)) - 1;
        chk("sleep", p, e);
        // divided sleep for the second scan
        host.wr(SLEEP_CONFIG_ADDR, 8'h20);
        run_en = 1'b0;
        wait_for(0, 1'b0, e);
        host.wr(PWR_CONFIG_ADDR, 8'h00);
        host.wr(ACQ_CONFIG_ADDR, 8'h00);
        // multiplied sleep, short enough to end before the next start
        host.wr(SLEEP_CONFIG_ADDR, 8'h11);
        for (int i = 0; i < 5; i++) begin
            repeat (SB * 20) @(negedge clk);
            pulse(status_clear);
            host.wr(IRQ_CONFIG_ADDR, {3'h0, codes[i], 2'h2});
            run_en = 1'b1;
            wait_for(1, 1'b1, e);
            repeat (CONV_CYCLES + 3) @(negedge clk);
            chk("irq_mid", codes[i] inside {1, 2, 3, 7}, irq_pin);
            chk("chan_mid", 1, channel);
            run_en = 1'b0;
            repeat (3) wait_for(0, 1'b1, e);
            wait_for(0, 1'b0, e);
            repeat (2) @(negedge clk);
            chk("irq_end", codes[i] inside {2, 6}, irq_pin);
            chk("chan_wrap", 0, channel);
        end
        repeat (SB * 20) @(negedge clk);
        host.wr(IRQ_CONFIG_ADDR, 8'h00);
        pulse(status_clear);
        pulse(alarm);
        chk("irq_alarm", 0, irq_pin);
        pulse(status_clear);
        chk("irq_clear", 1, irq_pin);
        host.wr(IRQ_CONFIG_ADDR, 8'h01);
        alarm = 1'b1;
        n = 0;
        repeat (5) begin
            @(negedge clk);
            alarm = 1'b0;
            n += (irq_pin === 1'b0);
        end
        chk("irq_pulse", 1, n);
        // busy pulse on the pin, alarm still the control event
        host.wr(IRQ_CONFIG_ADDR, 8'h05);
        host.wr(SLEEP_CONFIG_ADDR, 8'h40);
        pulse(alarm);
        run_en = 1'b1;
        repeat (10) @(negedge clk);
        chk("halt", 0, busy);
        pulse(status_clear);
        repeat (3) @(negedge clk);
        chk("resume", 1, busy);
        run_en = 1'b0;
        finish_test();
    end
endmodule : adc_sequencer_timing_config_tb
`default_nettype wire
